/* dv/spi_slave_model.sv */
// Behavioural serial slave answering the engine's transfers
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss,
  input  wire logic       clock_polarity_select,
  input  wire logic       clock_phase_select,
  input  wire logic       lsbFirst,
  input  wire logic [7:0] txByte,
  output var  logic       miso,
  output var  logic [7:0] rxByte,
  output var  int         frames
);
  logic [7:0] shp;
  logic       outBit = 1'b0;
  int         k, s;
  initial frames = 0;
  // Selection loads the reply; phase 0 shows its first bit at once
  always @(negedge ss) begin
    shp = txByte;
    k = clock_phase_select ? 0 : 1;
    s = 0;
    if (!clock_phase_select) outBit = lsbFirst ? shp[0] : shp[7];
  end
  // Phase 0 samples on the leading edge, phase 1 on the trailing one
  always @(sck) if (!ss) begin
    if ((sck != clock_polarity_select) != clock_phase_select) begin
      rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      s++;
      if (s == 8) frames++;
    end else if (k < 8) begin
      outBit = lsbFirst ? shp[k] : shp[7 - k];
      k++;
    end
  end
  // Deselected, the line floats: show the inverse of the last bit
  assign miso = ss ? ~outBit : outBit;
endmodule // spi_slave_model
`default_nettype wire

/* dv/spi_xfer_asserts.sv */
// Concurrent checks on the engine's bus and serial pins
`timescale 1ns/1ps
`default_nettype none
module spi_xfer_asserts
  import spi_xfer_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire spi_pins_t   pinIn,
  input wire spi_pins_t   pinOut,
  input wire spi_pins_t   pinOe,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Bus: one wait cycle, answer stands one cycle, upper bytes read zero
  property p_waitOne;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("slow");
  property p_waitPulse;
    !waitrequest |=> waitrequest;
  endproperty
  a_waitPulse: assert property (p_waitPulse) else $error("long");
  property p_upperZero;
    read && !waitrequest |-> readdata[31:8] == 24'h00_0000;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper");
  // Leaving reset the bus and the link are quiet
  property p_resetIdle;
    $rose(arst_n) |-> waitrequest && !irq && !pinOe.sck;
  endproperty
  a_resetIdle: assert property (p_resetIdle) else $error("idle");
  // Select stays low for at least eight clock cycles after it falls and stays high the cycle after it rises
  property p_ssFrame;
    $fell(pinOut.ss) && pinOe.ss |-> !pinOut.ss [*8];
  endproperty
  a_ssFrame: assert property (p_ssFrame) else $error("frame");
  property p_ssGap;
    $rose(pinOut.ss) && pinOe.ss |=> pinOut.ss;
  endproperty
  a_ssGap: assert property (p_ssGap) else $error("gap");
  // Clock moves only inside a frame; register writes may move its idle level
  property p_sckFramed;
    $changed(pinOut.sck) && pinOe.sck && pinOe.ss && !$past(write)
      && !$past(write, 2) && !$past(write, 3) |-> !pinOut.ss;
  endproperty
  a_sckFramed: assert property (p_sckFramed) else $error("sck");
  // Clock and data drivers switch together; a master never drives its input
  property p_drvPair;
    pinOe.sck == pinOe.mosi && !(pinOe.sck && pinOe.miso);
  endproperty
  a_drvPair: assert property (p_drvPair) else $error("drv");
  // Main scenarios
  c_frame: cover property ($fell(pinOut.ss));
  c_irq: cover property ($rose(irq));
  c_fault: cover property ($fell(pinOe.sck));
  c_slave: cover property ($rose(pinOe.miso));
endmodule // spi_xfer_asserts
bind spi_transfer_engine spi_xfer_asserts u_spi_xfer_asserts (
  .clk(clk), .arst_n(arst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .irq(irq));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the serial transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spi_xfer_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic        ssIn = 1'b1, waitrequest, irq, slvMiso;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rdv;
  logic [7:0]  ctl = 8'h12, mine = 8'h00, slvTx = 8'h00, slvRx, heard;
  logic        extSck = 1'b0, extMosi = 1'b0;
  // Slave cases: controls for the outside master's formats
  logic [7:0]  sCtl [3] = '{8'h00, 8'h0D, 8'h09};
  spi_pins_t   pinIn, pinOut, pinOe;
  int          slvFrames, f0, n_mismatch = 0, samples_checked = 0;
  // Rows: control, byte sent, byte the slave returns
  logic [23:0] rows [6] = '{24'h12_5AC3, 24'h1A_3C96, 24'h16_A50F,
                            24'h1E_81F0, 24'h13_6D24, 24'h17_1E88};
  always #5 clk = ~clk;
  // Released clock and data lines follow the outside master, starting low
  assign pinIn = '{sck: pinOe.sck ? pinOut.sck : extSck,
                   mosi: pinOe.mosi ? pinOut.mosi : extMosi,
                   miso: pinOe.miso ? pinOut.miso : slvMiso, ss: ssIn};
  spi_transfer_engine u_spi_transfer_engine (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));
  spi_slave_model u_spi_slave_model (
    .sck(pinIn.sck), .mosi(pinIn.mosi), .ss(pinOe.ss ? pinOut.ss : 1'b1),
    .clock_polarity_select(ctl[3]), .clock_phase_select(ctl[2]), .lsbFirst(ctl[0]), .txByte(slvTx),
    .miso(slvMiso), .rxByte(slvRx), .frames(slvFrames));
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    int t;
    t = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    chk(t < 20, 1'b1, "bus");
  endtask
  // Polls status until a received byte is flagged
  task automatic waitRx();
    do bus(1'b0, 5'h0C, 8'h00); while (rdv[7] !== 1'b1);
  endtask
  // Outside master: clock to idle, select, eight bits, then release
  task automatic ext(input logic [7:0] m, output logic [7:0] r);
    extSck <= ctl[3];
    repeat (8) @(posedge clk);
    ssIn <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (!ctl[2]) extMosi <= m[ctl[0] ? b : 7 - b];
      repeat (8) @(posedge clk);
      extSck <= ~ctl[3];
      if (ctl[2]) extMosi <= m[ctl[0] ? b : 7 - b];
      else r[ctl[0] ? b : 7 - b] = pinIn.miso;
      repeat (8) @(posedge clk);
      extSck <= ctl[3];
      if (ctl[2]) r[ctl[0] ? b : 7 - b] = pinIn.miso;
    end
    repeat (8) @(posedge clk);
    ssIn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, 5'h04, 8'h10);
    bus(1'b1, 5'h00, ctl);
    f0 = slvFrames;
    bus(1'b1, 5'h10, 8'h99);
    repeat (200) @(posedge clk);
    chk(slvFrames, f0, "unarmed");
    bus(1'b0, 5'h0C, 8'h00);
    chk(rdv, 32'h0000_0020, "status");
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      {ctl, mine, slvTx} = rows[i];
      bus(1'b1, 5'h00, ctl);
      bus(1'b0, 5'h0C, 8'h00);
      bus(1'b1, 5'h10, mine);
      waitRx();
      bus(1'b0, 5'h10, 8'h00);
      chk(rdv, {24'h00_0000, slvTx}, "rx");
      chk(slvRx, mine, "tx");
      bus(1'b0, 5'h0C, 8'h00);
      chk(rdv[7], 1'b0, "rx flag");
      $display("row %0d done", i);
    end
    // Two queued bytes; the second reply meets an unread buffer
    ctl = 8'h12;
    slvTx = 8'hA5;
    bus(1'b1, 5'h00, ctl);
    f0 = slvFrames;
    bus(1'b0, 5'h0C, 8'h00);
    bus(1'b1, 5'h10, 8'h11);
    bus(1'b0, 5'h0C, 8'h00);
    chk(rdv[5], 1'b1, "empty again");
    bus(1'b1, 5'h10, 8'h22);
    while (slvFrames == f0) @(posedge clk);
    slvTx = 8'h3C;
    while (slvFrames != f0 + 2 || pinOut.ss !== 1'b1) @(posedge clk);
    chk(slvRx, 8'h22, "queued");
    waitRx();
    bus(1'b0, 5'h10, 8'h00);
    chk(rdv, 32'h0000_00A5, "overrun");
    $display("queue test done");
    // Another master pulls the select input low
    bus(1'b1, 5'h00, 8'hB0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "tx irq");
    bus(1'b1, 5'h00, 8'h90);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "masked");
    ssIn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1, "fault irq");
    chk(pinOe.sck | pinOe.mosi, 1'b0, "drivers");
    ssIn <= 1'b1;
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b0, 5'h0C, 8'h00);
    chk(rdv[4], 1'b1, "fault held");
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b0, 5'h0C, 8'h00);
    chk(rdv[4], 1'b0, "fault clear");
    $display("fault test done");
    // Outside master drives the engine as a slave in three formats
    foreach (sCtl[j]) begin
      ctl = sCtl[j];
      bus(1'b1, 5'h00, ctl);
      bus(1'b0, 5'h0C, 8'h00);
      bus(1'b1, 5'h10, 8'h3A);
      ext(8'hC5, heard);
      waitRx();
      bus(1'b0, 5'h10, 8'h00);
      chk(rdv, 32'h0000_00C5, "slave rx");
      chk(heard, 8'h3A, "slave tx");
      $display("slave case %0d done", j);
    end
    // Reset in the middle of a transfer leaves the engine idle
    ctl = 8'h12;
    bus(1'b1, 5'h00, ctl);
    bus(1'b0, 5'h0C, 8'h00);
    bus(1'b1, 5'h10, 8'h5A);
    repeat (40) @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pinOe, 32'h0000_0000, "reset drivers");
    chk(pinOut.ss, 1'b1, "reset select");
    chk(waitrequest, 1'b1, "reset wait");
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 5'h0C, 8'h00);
    chk(rdv, 32'h0000_0020, "reset status");
    $display("mid reset test done");
    give_verdict();
  end
  // Watchdog: the run needs far fewer than 20000 cycles
  initial begin
    #200_000;
    chk(1'b0, 1'b1, "timeout");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

/* hw/spi_transfer_engine.sv */
// Byte-wide serial transfer engine with Avalon-MM register access
// Functional notes
// - data write loads buffer; master write starts transfer
// - data read returns receive buffer byte
// - byte received into full buffer is silently dropped
// - free shifter takes queued byte, empty flag sets
// - sample on one edge, shift half later
// - after eight bits, store byte, set full
// - queued byte at end starts next transfer
// - MSB first unless LSB-first select set
// - polarity inverts clock; four formats with phase
// - phase 1 select low half early, high at end
// - phase 0 select low at start, high half later
// - phase 1 slave: first edge shifts, second samples
// - phase 0 slave drives first bit when selected
// - interrupt from receive/fault or transmit empty enables
// - select input faults only for master, fault-enable, no output
// - fault drops master, disables clock and data drivers
// - fault flag clears by read-then-control-write
// - receive flag clears by status read, data read
// - data write counts only after status read saw empty
// - idle write moves to shifter, flag back in two
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_xfer_defs.svh"
module spi_transfer_engine
  import spi_xfer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire spi_pins_t   pinIn,
  output var  spi_pins_t   pinOut,
  output var  spi_pins_t   pinOe,
  output var  logic        irq
);

  // Whole engine state; one record keeps the next-value logic in one place
  typedef struct packed {
    ctrl_t       ctrl;
    logic [7:0]  baud;
    mstate_t     state;
    logic [7:0]  halfCnt;
    logic [4:0]  edgeCnt;
    logic        sckLvl;
    logic [3:0]  bitCnt;
    logic [7:0]  shifter;
    logic        shFull;
    logic        sample;
    logic [7:0]  txBuf;
    logic        txEmpty;
    logic [7:0]  rxBuf;
    logic        rxFull;
    logic        mode_fault_flag;
    logic        txArm;
    logic        rxArm;
    logic        modfArm;
    logic        waitReq;
    logic [31:0] rdData;
    logic        irq;
    spi_pins_t   pOut;
    spi_pins_t   pOe;
  } eng_t;

  localparam eng_t ENG_RST = '{
    ctrl: '0, baud: `BAUD_HALF_RST, state: ST_IDLE, halfCnt: '0,
    edgeCnt: '0, sckLvl: 1'b0, bitCnt: '0, shifter: '0, shFull: 1'b0,
    sample: 1'b0, txBuf: '0, txEmpty: 1'b1, rxBuf: '0, rxFull: 1'b0,
    mode_fault_flag: 1'b0, txArm: 1'b0, rxArm: 1'b0, modfArm: 1'b0,
    waitReq: 1'b1, rdData: '0, irq: 1'b0, pOut: 4'h1, pOe: '0
  };

  eng_t      e_ff;
  eng_t      nxt_e;
  spi_pins_t sync1_ff;
  spi_pins_t sync2_ff;
  spi_pins_t sync3_ff;

  // Pins come from another clock domain; two stages before any use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      sync3_ff <= 4'hF;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Next-value logic for bus, flags, master sequencer and slave shifter
  always_comb begin
    logic       accept;
    logic       doShift;
    logic       doDone;
    logic       shiftIn;
    logic       halfDone;
    logic       selected;
    logic       sckEdge;
    logic       leading;
    logic       fault;
    logic [4:0] edgeNum;
    nxt_e    = e_ff;
    accept   = (read | write) & ~e_ff.waitReq;
    doShift  = 1'b0;
    doDone   = 1'b0;
    shiftIn  = 1'b0;
    halfDone = (e_ff.halfCnt == e_ff.baud);
    edgeNum  = e_ff.edgeCnt + 5'h01;
    selected = ~e_ff.ctrl.master & ~sync2_ff.ss;
    sckEdge  = sync2_ff.sck ^ sync3_ff.sck;
    leading  = sckEdge & (sync2_ff.sck ^ e_ff.ctrl.clock_polarity_select);
    fault    = e_ff.ctrl.master & e_ff.ctrl.mode_fault_enable & ~e_ff.ctrl.select_output_enable
             & ~sync2_ff.ss;

    // Bus slave: capture read data first, act on the accepting edge
    if ((read | write) & e_ff.waitReq) begin
      nxt_e.waitReq = 1'b0;
      nxt_e.rdData  = '0;
      unique case (address[4:2])
        `OFS_FIRST_CONTROL: begin
          nxt_e.rdData[`C1_RX_FAULT_IRQ_EN] = e_ff.ctrl.rxIe;
          nxt_e.rdData[`C1_TX_EMPTY_IRQ_EN] = e_ff.ctrl.txIe;
          nxt_e.rdData[`C1_MASTER_SELECT]   = e_ff.ctrl.master;
          nxt_e.rdData[`C1_CLOCK_POLARITY]  = e_ff.ctrl.clock_polarity_select;
          nxt_e.rdData[`C1_CLOCK_PHASE]     = e_ff.ctrl.clock_phase_select;
          nxt_e.rdData[`C1_SELECT_OUT_EN]   = e_ff.ctrl.select_output_enable;
          nxt_e.rdData[`C1_LSB_FIRST]       = e_ff.ctrl.lsbFirst;
        end
        `OFS_SECOND_CONTROL: begin
          nxt_e.rdData[`C2_MODE_FAULT_EN] = e_ff.ctrl.mode_fault_enable;
          nxt_e.rdData[`C2_BIDIR_MODE]    = e_ff.ctrl.bidir;
        end
        `OFS_BAUD_HALF: nxt_e.rdData[7:0] = e_ff.baud;
        `OFS_SERIAL_STATUS: begin
          nxt_e.rdData[`ST_RX_FULL]    = e_ff.rxFull;
          nxt_e.rdData[`ST_TX_EMPTY]   = e_ff.txEmpty;
          nxt_e.rdData[`ST_MODE_FAULT] = e_ff.mode_fault_flag;
        end
        `OFS_SERIAL_DATA: nxt_e.rdData[7:0] = e_ff.rxBuf;
        default: nxt_e.rdData = '0; // Unmapped reads give zero
      endcase
    end else begin
      nxt_e.waitReq = 1'b1;
    end

    // Register side effects; clears come first so hardware sets win
    if (accept & write) begin
      unique case (address[4:2])
        `OFS_FIRST_CONTROL: begin
          nxt_e.ctrl.rxIe     = writedata[`C1_RX_FAULT_IRQ_EN];
          nxt_e.ctrl.txIe     = writedata[`C1_TX_EMPTY_IRQ_EN];
          nxt_e.ctrl.master   = writedata[`C1_MASTER_SELECT];
          nxt_e.ctrl.clock_polarity_select     = writedata[`C1_CLOCK_POLARITY];
          nxt_e.ctrl.clock_phase_select     = writedata[`C1_CLOCK_PHASE];
          nxt_e.ctrl.select_output_enable     = writedata[`C1_SELECT_OUT_EN];
          nxt_e.ctrl.lsbFirst = writedata[`C1_LSB_FIRST];
          if (e_ff.modfArm) begin
            nxt_e.mode_fault_flag    = 1'b0;
            nxt_e.modfArm = 1'b0;
          end
        end
        `OFS_SECOND_CONTROL: begin
          nxt_e.ctrl.mode_fault_enable = writedata[`C2_MODE_FAULT_EN];
          nxt_e.ctrl.bidir  = writedata[`C2_BIDIR_MODE];
        end
        `OFS_BAUD_HALF: nxt_e.baud = writedata[7:0];
        `OFS_SERIAL_DATA: begin
          // Unqualified writes are dropped so a full buffer is never lost
          if (e_ff.txArm & e_ff.txEmpty) begin
            nxt_e.txBuf   = writedata[7:0];
            nxt_e.txEmpty = 1'b0;
            nxt_e.txArm   = 1'b0;
          end
        end
        default: ; // Writes elsewhere have no effect
      endcase
    end
    if (accept & read) begin
      if (address[4:2] == `OFS_SERIAL_STATUS) begin
        nxt_e.txArm   = e_ff.rdData[`ST_TX_EMPTY];
        nxt_e.rxArm   = e_ff.rdData[`ST_RX_FULL];
        nxt_e.modfArm = e_ff.rdData[`ST_MODE_FAULT];
      end else if (address[4:2] == `OFS_SERIAL_DATA && e_ff.rxArm) begin
        nxt_e.rxFull = 1'b0;
        nxt_e.rxArm  = 1'b0;
      end
    end

    // Master sequencer: half-period timer drives clock edges
    unique case (e_ff.state)
      ST_IDLE: begin
        nxt_e.halfCnt = '0;
        nxt_e.edgeCnt = '0;
        nxt_e.sckLvl  = 1'b0;
        if (e_ff.ctrl.master & e_ff.shFull) begin
          nxt_e.state = e_ff.ctrl.clock_phase_select ? ST_LEAD : ST_RUN;
        end
      end
      ST_LEAD: begin
        nxt_e.halfCnt = e_ff.halfCnt + 8'h01;
        if (halfDone) begin
          nxt_e.halfCnt = '0;
          nxt_e.state   = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_e.halfCnt = e_ff.halfCnt + 8'h01;
        if (halfDone) begin
          nxt_e.halfCnt = '0;
          nxt_e.edgeCnt = edgeNum;
          nxt_e.sckLvl  = ~e_ff.sckLvl;
          // Odd edges sample in phase 0, even edges in phase 1
          if (edgeNum[0] ^ e_ff.ctrl.clock_phase_select) begin
            nxt_e.sample = sync2_ff.miso;
          end else if (edgeNum != 5'h01) begin
            doShift = 1'b1;
            shiftIn = e_ff.sample;
          end
          if (edgeNum == `LAST_EDGE) begin
            nxt_e.state = ST_TRAIL;
          end
        end
      end
      ST_TRAIL: begin
        nxt_e.halfCnt = e_ff.halfCnt + 8'h01;
        if (halfDone) begin
          nxt_e.state = ST_IDLE;
          doDone      = 1'b1;
          doShift     = e_ff.ctrl.clock_phase_select; // Last sample lands here
          shiftIn     = e_ff.sample;
        end
      end
    endcase

    // Slave shifter runs from the sampled external clock
    if (!selected) begin
      nxt_e.bitCnt = '0;
    end else if (sckEdge && leading && !e_ff.ctrl.clock_phase_select) begin
      nxt_e.sample = sync2_ff.mosi;
    end else if (sckEdge && !leading && !e_ff.ctrl.clock_phase_select) begin
      doShift      = 1'b1;
      shiftIn      = e_ff.sample;
      nxt_e.bitCnt = e_ff.bitCnt + 4'h1;
    end else if (sckEdge && leading && e_ff.bitCnt != 4'h0) begin
      doShift = 1'b1;
      shiftIn = e_ff.sample;
    end else if (sckEdge && !leading) begin
      nxt_e.sample = sync2_ff.mosi;
      nxt_e.bitCnt = e_ff.bitCnt + 4'h1;
      if (e_ff.bitCnt == `BITS_PER_BYTE - 4'h1) begin
        doShift = 1'b1; // No later edge to shift the last bit
        shiftIn = sync2_ff.mosi;
      end
    end
    if (selected && nxt_e.bitCnt == `BITS_PER_BYTE) begin
      nxt_e.bitCnt = '0;
      doDone       = 1'b1;
    end

    // Shift and completion shared by both roles
    if (doShift) begin
      nxt_e.shifter = e_ff.ctrl.lsbFirst
                    ? {shiftIn, e_ff.shifter[7:1]}
                    : {e_ff.shifter[6:0], shiftIn};
    end
    if (doDone) begin
      nxt_e.shFull = 1'b0;
      if (!nxt_e.rxFull) begin // Same-cycle read frees it
        nxt_e.rxBuf  = nxt_e.shifter;
        nxt_e.rxFull = 1'b1;
      end
    end else if (!e_ff.shFull && !e_ff.txEmpty && e_ff.state == ST_IDLE
                 && (e_ff.bitCnt == 4'h0)) begin
      // Queued byte moves only between bytes, so next one follows on
      nxt_e.shifter = e_ff.txBuf;
      nxt_e.shFull  = 1'b1;
      nxt_e.txEmpty = 1'b1;
    end

    // Mode fault aborts the master and falls back to slave
    if (fault) begin
      nxt_e.mode_fault_flag        = 1'b1;
      nxt_e.ctrl.master = 1'b0;
      nxt_e.state       = ST_IDLE;
      nxt_e.sckLvl      = 1'b0;
    end

    // Outputs registered from next state so pins follow without lag
    nxt_e.irq = ((nxt_e.rxFull | nxt_e.mode_fault_flag) & nxt_e.ctrl.rxIe)
              | (nxt_e.txEmpty & nxt_e.ctrl.txIe);
    nxt_e.pOut.sck  = nxt_e.sckLvl ^ nxt_e.ctrl.clock_polarity_select;
    nxt_e.pOut.mosi = nxt_e.ctrl.lsbFirst ? nxt_e.shifter[0]
                                          : nxt_e.shifter[7];
    nxt_e.pOut.miso = nxt_e.pOut.mosi;
    nxt_e.pOut.ss   = (nxt_e.state == ST_IDLE);
    nxt_e.pOe.sck   = nxt_e.ctrl.master;
    nxt_e.pOe.mosi  = nxt_e.ctrl.master;
    nxt_e.pOe.ss    = nxt_e.ctrl.master & nxt_e.ctrl.mode_fault_enable
                    & nxt_e.ctrl.select_output_enable;
    nxt_e.pOe.miso  = ~nxt_e.ctrl.master & ~sync2_ff.ss
                    & ~(nxt_e.mode_fault_flag & ~nxt_e.ctrl.bidir);
  end

  // Engine state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      e_ff <= ENG_RST;
    end else begin
      e_ff <= nxt_e;
    end
  end

  assign readdata    = e_ff.rdData;
  assign waitrequest = e_ff.waitReq;
  assign pinOut      = e_ff.pOut;
  assign pinOe       = e_ff.pOe;
  assign irq         = e_ff.irq;

endmodule // spi_transfer_engine
`default_nettype wire

/* hw/spi_xfer_defs.svh */
// Register offsets, field positions, reset values and timing of the engine
`ifndef SPI_XFER_DEFS_SVH
`define SPI_XFER_DEFS_SVH
`define OFS_FIRST_CONTROL 3'h0
`define OFS_SECOND_CONTROL 3'h1
`define OFS_BAUD_HALF 3'h2
`define OFS_SERIAL_STATUS 3'h3
`define OFS_SERIAL_DATA 3'h4
`define C1_RX_FAULT_IRQ_EN 7
`define C1_TX_EMPTY_IRQ_EN 5
`define C1_MASTER_SELECT 4
`define C1_CLOCK_POLARITY 3
`define C1_CLOCK_PHASE 2
`define C1_SELECT_OUT_EN 1
`define C1_LSB_FIRST 0
`define C2_MODE_FAULT_EN 4
`define C2_BIDIR_MODE 3
`define ST_RX_FULL 7
`define ST_TX_EMPTY 5
`define ST_MODE_FAULT 4
`define BAUD_HALF_RST 8'h07
`define LAST_EDGE 5'h10
`define BITS_PER_BYTE 4'h8
`endif

/* hw/spi_xfer_pkg.sv */
// Types shared by the serial transfer engine
`default_nettype none
package spi_xfer_pkg;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spi_pins_t;

  typedef struct packed {
    logic rxIe;
    logic txIe;
    logic master;
    logic clock_polarity_select;
    logic clock_phase_select;
    logic select_output_enable;
    logic lsbFirst;
    logic mode_fault_enable;
    logic bidir;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_RUN   = 2'b10,
    ST_TRAIL = 2'b11
  } mstate_t;
endpackage
`default_nettype wire
